// *** verilog/lbst_pkg.sv ***
package lbst_pkg;
  typedef enum logic [1:0] {MODE_BASIC, MODE_PIPE, MODE_XAUI, MODE_OTHER} lbst_mode_t;
  typedef enum logic [2:0] {LB_NONE, LB_REV_PAR, LB_SERIAL, LB_RSER_PRE, LB_RSER_POST} lbst_lpbk_t;
  typedef enum logic [1:0] {PAT_OFF, PAT_INCR, PAT_HF, PAT_LF} lbst_pat_t;

  // -----------------------------------------------------------------
  // Datapath constants
  // -----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam logic [15:0] INCR_FIRST = 16'h0000;
  localparam logic [15:0] INCR_LAST = 16'h00FF;
  localparam logic [8:0] INCR_WORDS = 9'h100;
  localparam logic [15:0] ALIGN_WORD = 16'hF628;
  localparam logic [15:0] HF_WORD = 16'hAAAA;
  localparam logic [3:0] LF_RUN = 4'h5;
  localparam logic [3:0] LF_LEN = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] TX_HALF = 4'h8;
  localparam logic [3:0] OPT_ALL = 4'hF;

  // -----------------------------------------------------------------
  // Controller registers
  // -----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PIPE = 5'h04;
  localparam logic [4:0] REG_TXD = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0C;
  localparam logic [4:0] REG_RXD = 5'h10;
  localparam logic [31:0] CTRL_MASK = 32'h00000FFF;
  localparam logic [31:0] PIPE_MASK = 32'h0000000F;
  localparam logic [31:0] TXD_MASK = 32'h0000FFFF;
  localparam logic [31:0] REG_RST = 32'h00000000;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_LPBK = 2;
  localparam int CTRL_PAT = 5;
  localparam int CTRL_OPTS = 7;
  localparam int CTRL_PRE = 11;
  localparam int PIPE_PWR = 0;
  localparam int PIPE_REQ = 1;
  localparam int PIPE_TXR = 2;
  localparam int PIPE_RXR = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verilog/lbst_if.sv ***
`timescale 1ns/100ps
interface lbst_if;
  import lbst_pkg::*;
  logic cfg_valid;
  logic cfg_ready;
  lbst_mode_t cfg_mode;
  lbst_lpbk_t cfg_lpbk;
  lbst_pat_t cfg_pat;
  logic [3:0] cfg_opts;
  logic cfg_preemph;
  logic full_power_state;
  logic lpbk_req;
  logic tx_pcs_rst;
  logic rx_pcs_rst;
  logic [15:0] tx_data;
  logic [15:0] rx_data;
  logic rx_valid;
  logic rx_aligned;
  logic bist_err;
  logic bist_done;
  logic preemph_on;
  lbst_lpbk_t lpbk_active;

  modport dev (
    input cfg_valid, cfg_mode, cfg_lpbk, cfg_pat, cfg_opts, cfg_preemph,
    input full_power_state, lpbk_req, tx_pcs_rst, rx_pcs_rst, tx_data,
    output cfg_ready, rx_data, rx_valid, rx_aligned, bist_err, bist_done, preemph_on, lpbk_active
  );
  modport ctl (
    output cfg_valid, cfg_mode, cfg_lpbk, cfg_pat, cfg_opts, cfg_preemph,
    output full_power_state, lpbk_req, tx_pcs_rst, rx_pcs_rst, tx_data,
    input cfg_ready, rx_data, rx_valid, rx_aligned, bist_err, bist_done, preemph_on, lpbk_active
  );
endinterface

// *** verilog/lbst_chan.sv ***
`timescale 1ns/100ps
module lbst_chan
  import lbst_pkg::*;
#(
  parameter int FABRIC_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fabric side
  lbst_if.dev ch,
  // Serial side
  input wire logic ser_rx_clk,
  input wire logic ser_rx_d,
  output logic ser_tx_clk,
  output logic ser_tx_d
);
  lbst_mode_t mode_q;
  lbst_lpbk_t lpbk_q;
  lbst_lpbk_t lpbk_ok;
  lbst_lpbk_t lb_sel;
  lbst_pat_t pat_q;
  lbst_pat_t pat_ok;
  logic pre_q;
  logic preemph_q;
  logic rc1_q, rc2_q, rc3_q, rd1_q, rd2_q, cdr_q;
  logic rx_rise;
  logic [3:0] div_q;
  logic tclk_q;
  logic tx_fall, tx_rise, tx_bit;
  logic [15:0] sh_q, src_word;
  logic [3:0] scnt_q, lfc_q;
  logic stx_d_q, stx_c_q;
  logic din, dstb;
  logic [15:0] dsh_q, dsh_d, rxw_q;
  logic [3:0] dcnt_q;
  logic aligned_q, wstb_q;
  logic [15:0] rx_data_q;
  logic rx_valid_q;
  logic [15:0] gen_q, lbw_q, exp_q;
  logic lbv_q, seen_q, err_q, done_q;
  logic [8:0] cnt_q;

  function automatic logic [15:0] incr_next(input logic [15:0] w);
    incr_next = (w == INCR_LAST) ? INCR_FIRST : w + 16'h0001;
  endfunction

  // -----------------------------------------------------------------
  // Channel configuration
  // -----------------------------------------------------------------
  always_comb begin
    unique case (ch.cfg_lpbk)
      LB_SERIAL: lpbk_ok = (ch.cfg_mode != MODE_PIPE) ? LB_SERIAL : LB_NONE;
      LB_RSER_PRE: lpbk_ok = (ch.cfg_mode != MODE_XAUI) ? LB_RSER_PRE : LB_NONE;
      LB_RSER_POST: lpbk_ok = (ch.cfg_mode != MODE_XAUI) ? LB_RSER_POST : LB_NONE;
      default: lpbk_ok = LB_NONE;
    endcase
  end

  always_comb begin
    pat_ok = PAT_OFF;
    if (ch.cfg_mode == MODE_BASIC) begin
      if (ch.cfg_pat != PAT_INCR || (ch.cfg_opts == OPT_ALL && FABRIC_W == WORD_W)) begin
        pat_ok = ch.cfg_pat;
      end
    end
  end

  // The loopback and pattern settings move only on a reconfiguration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_BASIC;
      lpbk_q <= LB_NONE;
      pat_q <= PAT_OFF;
      pre_q <= 1'b0;
    end else if (ch.cfg_valid) begin
      mode_q <= ch.cfg_mode;
      lpbk_q <= lpbk_ok;
      pat_q <= pat_ok;
      pre_q <= ch.cfg_preemph;
    end
  end

  assign ch.cfg_ready = 1'b1;
  assign lb_sel = (mode_q == MODE_PIPE && ch.lpbk_req && ch.full_power_state) ? LB_REV_PAR : lpbk_q;
  assign ch.lpbk_active = lb_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preemph_q <= 1'b0;
    end else begin
      preemph_q <= pre_q && (lb_sel != LB_RSER_PRE);
    end
  end

  assign ch.preemph_on = preemph_q;

  // -----------------------------------------------------------------
  // Serial input capture and clock recovery
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc1_q <= 1'b0;
      rc2_q <= 1'b0;
      rc3_q <= 1'b0;
      rd1_q <= 1'b0;
      rd2_q <= 1'b0;
    end else begin
      rc1_q <= ser_rx_clk;
      rc2_q <= rc1_q;
      rc3_q <= rc2_q;
      rd1_q <= ser_rx_d;
      rd2_q <= rd1_q;
    end
  end

  assign rx_rise = rc2_q && !rc3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdr_q <= 1'b0;
    end else if (rx_rise) begin
      cdr_q <= rd2_q;
    end
  end

  // -----------------------------------------------------------------
  // Transmit bit clock and serializer
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      tclk_q <= 1'b0;
    end else if (div_q == TX_HALF - 4'h1) begin
      div_q <= 4'h0;
      tclk_q <= !tclk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign tx_fall = (div_q == TX_HALF - 4'h1) && tclk_q;
  assign tx_rise = (div_q == TX_HALF - 4'h1) && !tclk_q;

  always_comb begin
    if (lb_sel == LB_REV_PAR) begin
      src_word = rxw_q;
    end else if (pat_q == PAT_INCR) begin
      src_word = gen_q;
    end else if (pat_q == PAT_HF) begin
      src_word = HF_WORD;
    end else begin
      src_word = ch.tx_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ch.tx_pcs_rst) begin
      sh_q <= 16'h0000;
      scnt_q <= 4'h0;
      lfc_q <= 4'h0;
    end else if (tx_fall) begin
      lfc_q <= (lfc_q == LF_LEN - 4'h1) ? 4'h0 : lfc_q + 4'h1;
      if (scnt_q == BIT_LAST) begin
        sh_q <= src_word;
        scnt_q <= 4'h0;
      end else begin
        sh_q <= {sh_q[14:0], 1'b0};
        scnt_q <= scnt_q + 4'h1;
      end
    end
  end

  assign tx_bit = (pat_q == PAT_LF) ? (lfc_q < LF_RUN) : sh_q[15];

  // The output buffer carries either the serializer or one of the reverse paths.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stx_d_q <= 1'b0;
      stx_c_q <= 1'b0;
    end else begin
      unique case (lb_sel)
        LB_RSER_PRE: begin
          stx_d_q <= rd2_q;
          stx_c_q <= !rc2_q;
        end
        LB_RSER_POST: begin
          stx_d_q <= cdr_q;
          stx_c_q <= !rc3_q;
        end
        default: begin
          stx_d_q <= tx_bit;
          stx_c_q <= tclk_q;
        end
      endcase
    end
  end

  assign ser_tx_d = stx_d_q;
  assign ser_tx_clk = stx_c_q;

  // -----------------------------------------------------------------
  // Deserializer and word aligner
  // -----------------------------------------------------------------
  assign din = (lb_sel == LB_SERIAL) ? tx_bit : rd2_q;
  assign dstb = (lb_sel == LB_SERIAL) ? tx_rise : rx_rise;
  assign dsh_d = {dsh_q[14:0], din};

  always_ff @(posedge aclk) begin
    if (!aresetn || ch.rx_pcs_rst || ch.cfg_valid) begin
      dsh_q <= 16'h0000;
      dcnt_q <= 4'h0;
      aligned_q <= 1'b0;
      rxw_q <= 16'h0000;
      wstb_q <= 1'b0;
    end else begin
      wstb_q <= 1'b0;
      if (dstb) begin
        dsh_q <= dsh_d;
        if (!aligned_q) begin
          if (dsh_d == ALIGN_WORD) begin
            aligned_q <= 1'b1;
            dcnt_q <= 4'h0;
            rxw_q <= dsh_d;
            wstb_q <= 1'b1;
          end
        end else if (dcnt_q == BIT_LAST) begin
          dcnt_q <= 4'h0;
          rxw_q <= dsh_d;
          wstb_q <= 1'b1;
        end else begin
          dcnt_q <= dcnt_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ch.rx_pcs_rst) begin
      rx_data_q <= 16'h0000;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= wstb_q && (pat_q != PAT_INCR);
      if (wstb_q && pat_q != PAT_INCR) begin
        rx_data_q <= rxw_q;
      end
    end
  end

  assign ch.rx_data = rx_data_q;
  assign ch.rx_valid = rx_valid_q;
  assign ch.rx_aligned = aligned_q;

  // -----------------------------------------------------------------
  // Incremental generator and checker
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || ch.tx_pcs_rst) begin
      gen_q <= INCR_FIRST;
    end else if (pat_q == PAT_INCR) begin
      gen_q <= incr_next(gen_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ch.rx_pcs_rst) begin
      lbw_q <= 16'h0000;
      lbv_q <= 1'b0;
    end else begin
      lbw_q <= gen_q;
      lbv_q <= (pat_q == PAT_INCR) && !ch.tx_pcs_rst;
    end
  end

  // The checker locks on the first word it sees, then expects each next value.
  always_ff @(posedge aclk) begin
    if (!aresetn || ch.rx_pcs_rst) begin
      seen_q <= 1'b0;
      exp_q <= INCR_FIRST;
      cnt_q <= 9'h000;
      err_q <= 1'b0;
      done_q <= 1'b0;
    end else if (lbv_q) begin
      seen_q <= 1'b1;
      exp_q <= incr_next(lbw_q);
      if (cnt_q != INCR_WORDS - 9'h001) begin
        cnt_q <= cnt_q + 9'h001;
      end
      if (seen_q && lbw_q != exp_q) begin
        err_q <= 1'b1;
        done_q <= 1'b1;
      end
      if (cnt_q == INCR_WORDS - 9'h001) begin
        done_q <= 1'b1;
      end
    end
  end

  assign ch.bist_err = err_q;
  assign ch.bist_done = done_q;
endmodule

// *** verilog/lbst_ctl.sv ***
`timescale 1ns/100ps
module lbst_ctl
  import lbst_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel side
  lbst_if.ctl ch
);
  logic aw_q, w_q, do_wr, rd_hs;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] ctrl_q, pipe_q, txd_q, stat, rmux;
  logic pend_q, new_q;
  logic [15:0] rxd_q, txo_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    merge = o;
  endfunction

  // -----------------------------------------------------------------
  // Write channel
  // -----------------------------------------------------------------
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign do_wr = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= REG_RST;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_PIPE || awaddr_q == REG_TXD) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= REG_RST;
      pipe_q <= REG_RST;
      txd_q <= REG_RST;
    end else if (do_wr) begin
      if (awaddr_q == REG_CTRL) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
      end
      if (awaddr_q == REG_PIPE) begin
        pipe_q <= merge(pipe_q, wdata_q, wstrb_q) & PIPE_MASK;
      end
      if (awaddr_q == REG_TXD) begin
        txd_q <= merge(txd_q, wdata_q, wstrb_q) & TXD_MASK;
      end
    end
  end

  // -----------------------------------------------------------------
  // Reconfiguration and channel controls
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    end else if (do_wr && awaddr_q == REG_CTRL) begin
      pend_q <= 1'b1;
    end else if (ch.cfg_ready) begin
      pend_q <= 1'b0;
    end
  end

  assign ch.cfg_valid = pend_q;
  assign ch.cfg_mode = lbst_mode_t'(ctrl_q[CTRL_MODE +: 2]);
  assign ch.cfg_lpbk = lbst_lpbk_t'(ctrl_q[CTRL_LPBK +: 3]);
  assign ch.cfg_pat = lbst_pat_t'(ctrl_q[CTRL_PAT +: 2]);
  assign ch.cfg_opts = ctrl_q[CTRL_OPTS +: 4];
  assign ch.cfg_preemph = ctrl_q[CTRL_PRE];
  assign ch.full_power_state = pipe_q[PIPE_PWR];
  assign ch.lpbk_req = pipe_q[PIPE_REQ] && pipe_q[PIPE_PWR];
  assign ch.tx_pcs_rst = pipe_q[PIPE_TXR];
  assign ch.rx_pcs_rst = pipe_q[PIPE_RXR];

  // Until the aligner locks in serial loopback, the alignment word replaces user data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txo_q <= 16'h0000;
    end else begin
      txo_q <= (ch.lpbk_active == LB_SERIAL && !ch.rx_aligned) ? ALIGN_WORD : txd_q[15:0];
    end
  end

  assign ch.tx_data = txo_q;

  // -----------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  assign stat = {24'h000000, ch.preemph_on, pend_q, ch.bist_done, ch.bist_err, ch.rx_aligned, ch.lpbk_active};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= 16'h0000;
      new_q <= 1'b0;
    end else if (ch.rx_valid) begin
      rxd_q <= ch.rx_data;
      new_q <= 1'b1;
    end else if (rd_hs && s_axi_araddr == REG_RXD) begin
      new_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (s_axi_araddr)
      REG_CTRL: rmux = ctrl_q;
      REG_PIPE: rmux = pipe_q;
      REG_TXD: rmux = txd_q;
      REG_STAT: rmux = stat;
      REG_RXD: rmux = {15'h0000, new_q, rxd_q};
      default: rmux = REG_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= REG_RST;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= (s_axi_araddr == REG_CTRL || s_axi_araddr == REG_PIPE || s_axi_araddr == REG_TXD ||
                      s_axi_araddr == REG_STAT || s_axi_araddr == REG_RXD) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** tb/lbst_chk_sva.sv ***
`timescale 1ns/100ps
module lbst_chk
  import lbst_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Controller outputs
  input logic cfg_valid,
  input lbst_mode_t cfg_mode,
  input lbst_lpbk_t cfg_lpbk,
  input lbst_pat_t cfg_pat,
  input logic [3:0] cfg_opts,
  input logic full_power_state,
  input logic lpbk_req,
  input logic rx_pcs_rst,
  // Channel outputs
  input logic rx_valid,
  input logic rx_aligned,
  input logic bist_err,
  input logic bist_done,
  input logic preemph_on,
  input lbst_lpbk_t lpbk_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // Loopback selection
  // ---------------------------------------------------------------
  chk_revpar_cond: assert property (lpbk_active == LB_REV_PAR && !cfg_valid |->
    lpbk_req && full_power_state && cfg_mode == MODE_PIPE)
    else $error("reverse parallel loop without request");
  chk_serial_mode: assert property (!cfg_valid && lpbk_active == LB_SERIAL |-> cfg_mode != MODE_PIPE)
    else $error("serial loop in pipe mode");
  chk_rser_mode: assert property (!cfg_valid && lpbk_active inside {LB_RSER_PRE, LB_RSER_POST} |->
    cfg_mode != MODE_XAUI)
    else $error("reverse serial loop in xaui mode");
  chk_no_lpbk: assert property (!cfg_valid && cfg_lpbk == LB_NONE && !lpbk_req |-> lpbk_active == LB_NONE)
    else $error("loop path without selection");
  chk_preemph_off: assert property (lpbk_active == LB_RSER_PRE [*2] |-> !preemph_on)
    else $error("pre-emphasis in pre-cdr reverse loop");
  // ---------------------------------------------------------------
  // Pattern checker flags
  // ---------------------------------------------------------------
  chk_err_sticky: assert property (bist_err && !rx_pcs_rst |=> bist_err)
    else $error("error flag dropped");
  chk_err_done: assert property (bist_err |-> bist_done)
    else $error("error without done");
  chk_done_sticky: assert property (bist_done && !rx_pcs_rst |=> bist_done)
    else $error("done flag dropped");
  chk_rxrst_clear: assert property (rx_pcs_rst |=> !bist_err && !bist_done && !rx_valid && !rx_aligned)
    else $error("receive reset left state");
  chk_incr_quiet: assert property (cfg_pat == PAT_INCR && $past(cfg_pat, 3) == PAT_INCR &&
    cfg_mode == MODE_BASIC && cfg_opts == OPT_ALL && !cfg_valid |-> !rx_valid)
    else $error("pattern word shown to fabric");
endmodule

// *** tb/transceiver_loopback_selftest_tb.sv ***
`timescale 1ns/100ps
module transceiver_loopback_selftest_tb;
  import lbst_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ser_rx_clk = 1'b0;
  logic ser_rx_d = 1'b0;
  logic ser_rx_run = 1'b0;
  logic [15:0] rx_word = 16'h0000;
  logic [3:0] rx_bit = 4'h0;
  logic [2:0] lk_q = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, ser_tx_clk, ser_tx_d;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rword, bits;
  int fail_count = 0;
  int tests_run = 0;
  int i, j;
  logic [7:0] rows [8] = '{8'h48, 8'h09, 8'h0E, 8'h4A, 8'h93, 8'h6D, 8'h04, 8'h6F};
  logic [31:0] pctl [3] = '{32'h00000008, 32'h00000040, 32'h00000060};
  logic [15:0] pexp [3] = '{16'h1234, 16'hAAAA, 16'hF83E};
  always #5 aclk = ~aclk;
  // The link clock runs only while a test needs it; data move MSB first on its falling edge.
  always @(posedge aclk) begin
    lk_q <= lk_q + 3'h1;
    if (lk_q == 3'h7) begin
      ser_rx_clk <= ser_rx_run && !ser_rx_clk;
      if (ser_rx_clk || !ser_rx_run) begin
        ser_rx_d <= rx_word[4'hF - rx_bit];
        rx_bit <= rx_bit + 4'h1;
      end
    end
  end
  // ---------------------------------------------------------------
  // Both ends and the checker
  // ---------------------------------------------------------------
  lbst_if i_lbst_if();
  lbst_ctl i_lbst_ctl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ch(i_lbst_if));
  lbst_chan #(.FABRIC_W(16)) i_lbst_chan (.aclk(aclk), .aresetn(aresetn), .ch(i_lbst_if),
    .ser_rx_clk(ser_rx_clk), .ser_rx_d(ser_rx_d), .ser_tx_clk(ser_tx_clk), .ser_tx_d(ser_tx_d));
  lbst_chk i_lbst_chk (.aclk(aclk), .aresetn(aresetn), .cfg_valid(i_lbst_if.cfg_valid),
    .cfg_mode(i_lbst_if.cfg_mode), .cfg_lpbk(i_lbst_if.cfg_lpbk), .cfg_pat(i_lbst_if.cfg_pat),
    .cfg_opts(i_lbst_if.cfg_opts), .full_power_state(i_lbst_if.full_power_state),
    .lpbk_req(i_lbst_if.lpbk_req), .rx_pcs_rst(i_lbst_if.rx_pcs_rst), .rx_valid(i_lbst_if.rx_valid),
    .rx_aligned(i_lbst_if.rx_aligned), .bist_err(i_lbst_if.bist_err), .bist_done(i_lbst_if.bist_done),
    .preemph_on(i_lbst_if.preemph_on), .lpbk_active(i_lbst_if.lpbk_active));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task tmo;
    fail("wait ran out");
    give_verdict;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail(m);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Ready and valid are looked at 1 ns after an edge, which is what the next edge samples.
  task axi_wr(input logic [4:0] a, input logic [31:0] d);
    int k;
    logic a_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    for (k = 0; k < 50 && !b_ok; k++) begin
      #1;
      a_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
    if (!b_ok) tmo;
  endtask
  task axi_rd(input logic [4:0] a);
    int k;
    logic a_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    for (k = 0; k < 50 && !r_ok; k++) begin
      #1;
      a_ok = arvalid && arready;
      r_ok = rvalid && rready;
      rword = rdata;
      resp = rresp;
      @(posedge aclk);
      if (a_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
    if (!r_ok) tmo;
  endtask
  task expect_reg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      axi_rd(a);
      if ((rword & m) === e) break;
    end
    chk(rword & m, e, "register value");
  endtask
  task get_bits(input int n);
    int b, k;
    logic p;
    for (b = 0; b < n; b++) begin
      p = ser_tx_clk;
      for (k = 0; k < 40; k++) begin
        @(posedge aclk);
        #1;
        if (ser_tx_clk && !p) break;
        p = ser_tx_clk;
      end
      if (k == 40) tmo;
      bits = {bits[30:0], ser_tx_d};
    end
  endtask
  function automatic logic win(input logic [15:0] e);
    int r;
    win = 1'b0;
    for (r = 0; r <= 16; r++) if (bits[r+:16] === e) win = 1'b1;
  endfunction
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    expect_reg(REG_STAT, 32'h000000FF, 32'h00000000, 1);
    chk(resp, RESP_OKAY, "read response");
    axi_wr(5'h14, 32'h0000000F);
    chk(resp, RESP_SLVERR, "unmapped write response");
    expect_reg(REG_STAT, 32'h000000FF, 32'h00000000, 1);
    for (i = 0; i < 8; i++) begin
      axi_wr(REG_CTRL, {20'h00000, 1'b1, 6'h00, rows[i][4:0]});
      cyc(4);
      expect_reg(REG_STAT, 32'h00000087, {24'h000000, rows[i][7:5] != LB_RSER_PRE, 4'h0, rows[i][7:5]}, 1);
    end
    for (j = 0; j < 2; j++) begin
      axi_wr(REG_CTRL, (j == 1) ? 32'h00000013 : 32'h0000000F);
      ser_rx_run <= 1'b1;
      for (i = 1; i >= 0; i--) begin
        rx_word <= {16{i[0]}};
        cyc(60);
        #1;
        chk(ser_tx_d, i[0], "reverse serial output");
      end
      ser_rx_run <= 1'b0;
    end
    axi_wr(REG_TXD, 32'h00001234);
    for (j = 0; j < 3; j++) begin
      axi_wr(REG_CTRL, pctl[j]);
      if (j == 0) expect_reg(REG_STAT, 32'h00000008, 32'h00000008, 400);
      if (j == 0) expect_reg(REG_RXD, 32'h0001FFFF, 32'h00011234, 200);
      cyc(64);
      get_bits(32);
      chk(win(pexp[j]), 1, "serial output pattern");
      expect_reg(REG_STAT, 32'h00000030, 32'h00000000, 1);
    end
    for (j = 0; j < 2; j++) begin
      axi_wr(REG_CTRL, (j == 1) ? 32'h00000720 : 32'h000007A1);
      cyc(400);
      expect_reg(REG_STAT, 32'h00000030, 32'h00000000, 1);
    end
    axi_wr(REG_CTRL, 32'h000007A0);
    cyc(100);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000000, 1);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000020, 200);
    axi_wr(REG_PIPE, 32'h00000008);
    axi_wr(REG_PIPE, 32'h00000000);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000000, 1);
    axi_wr(REG_PIPE, 32'h00000004);
    axi_wr(REG_PIPE, 32'h00000000);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000030, 100);
    cyc(300);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000030, 1);
    axi_wr(REG_PIPE, 32'h00000008);
    axi_wr(REG_PIPE, 32'h00000000);
    expect_reg(REG_STAT, 32'h00000030, 32'h00000000, 1);
    axi_wr(REG_CTRL, 32'h00000001);
    for (j = 0; j < 4; j++) begin
      axi_wr(REG_PIPE, j);
      expect_reg(REG_STAT, 32'h00000007, (j == 3) ? 32'h00000001 : 32'h00000000, 1);
    end
    rx_word <= ALIGN_WORD;
    ser_rx_run <= 1'b1;
    expect_reg(REG_RXD, 32'h0001FFFF, {16'h0001, ALIGN_WORD}, 300);
    get_bits(32);
    chk(win(ALIGN_WORD), 1, "reverse parallel output");
    ser_rx_run <= 1'b0;
    axi_wr(REG_CTRL, 32'h00000000);
    cyc(4);
    expect_reg(REG_STAT, 32'h00000007, 32'h00000000, 1);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    expect_reg(REG_STAT, 32'h000000FF, 32'h00000000, 1);
    give_verdict;
  end
endmodule
